// ==== mbt_pkg.sv ====
// Operation
// RQ1: Register functions 3, 4, 6, 16 use address = remote register plus offset.
// RQ2: Fixed-translation master mode forces the offset to zero.
// RQ3: Slave-side translation to upstream register number uses offset zero.
// RQ4: Offset is a full sixteen-bit value, applied only in configurable master mode.
// RQ5: Configuring party keeps upstream register number at or below 8192.
// RQ6: Coil functions 1, 5, 15 start at ((remote + offset - 1) * 16) + 1.
// RQ7: Each register maps to sixteen aligned coils; start coil is register bit one.
// RQ8: No valid reply within timeout: retransmit the same frame and wait again.
// RQ9: At most two retransmissions, three transmissions total, then abandon.
// RQ10: Always-on driver mode keeps transmitter enabled, full duplex.
// RQ11: Handshake-follower mode drives transmitter only while CTS is asserted.
// RQ12: Two-wire mode gates driver with CTS and disables receiver while sending.
// RQ13: Link should normally be 9600 baud, 8 data bits, even parity, 1 stop.
// RQ14: Tx_follows_handshake line holds at most 32 slaves; multidrop off, full duplex.
// RQ15: Two-wire line needs multidrop on with half duplex.
// RQ16: Configurable master uses configured read code for reads, write code for writes.
// RQ17: Configurable mode picks code and offset; fixed mode uses standard translation.
// RQ18: Address arithmetic is sixteen-bit unsigned, wrapping modulo 65536.
package mbt_pkg;
    localparam logic [7:0]  FN_RD_COILS   = 8'h01;
    localparam logic [7:0]  FN_RD_HOLD    = 8'h03;
    localparam logic [7:0]  FN_RD_INPUT   = 8'h04;
    localparam logic [7:0]  FN_WR_COIL    = 8'h05;
    localparam logic [7:0]  FN_WR_REG     = 8'h06;
    localparam logic [7:0]  FN_WR_COILS   = 8'h0f;
    localparam logic [7:0]  FN_WR_REGS    = 8'h10;
    localparam logic [15:0] COILS_PER_REG = 16'h0010;
    localparam logic [15:0] COIL_BASE     = 16'h0001;
    localparam logic [1:0]  MAX_RETRIES   = 2'h2;
    localparam logic [15:0] OFFSET_RESET  = 16'h0000;
    localparam int          FIFO_DEPTH    = 32;

    typedef enum logic [1:0] {
        MBT_DRV_ALWAYS = 2'b00,
        MBT_DRV_FOLLOW = 2'b01,
        MBT_DRV_TWO    = 2'b10
    } mbt_drv_t;

    typedef enum logic [1:0] {
        MBT_IDLE = 2'b00,
        MBT_SEND = 2'b01,
        MBT_WAIT = 2'b10
    } mbt_state_t;

    function automatic logic is_coil_fn(input logic [7:0] fn);
        return fn == FN_RD_COILS || fn == FN_WR_COIL || fn == FN_WR_COILS;
    endfunction

    function automatic logic [15:0] coil_start(input logic [15:0] reg_addr);
        return 16'((reg_addr - COIL_BASE) * COILS_PER_REG + COIL_BASE);
    endfunction
endpackage

// ==== mbt_fifo.sv ====
module mbt_fifo
    import mbt_pkg::*;
#(
    parameter int WIDTH = 41,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   count;
        logic          room;
    } mbt_fifo_st_t;

    mbt_fifo_st_t     s;
    mbt_fifo_st_t     next_s;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    // Registered so the upstream ready comes straight from a flip-flop
    assign in_ready  = s.room;
    assign out_valid = s.count != '0;
    assign out_data  = mem[s.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_s = s;
        if (push) begin
            next_s.wr = AW'(s.wr + 1'b1);
        end
        if (pop) begin
            next_s.rd = AW'(s.rd + 1'b1);
        end
        next_s.count = (AW+1)'(s.count + push - pop);
        next_s.room  = next_s.count != (AW+1)'(DEPTH);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s      <= '0;
            s.room <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[s.wr] <= in_data;
        end
    end
endmodule

// ==== mbt_master_port.sv ====
// Master-side request translator: upstream request in, Modbus function/address out,
// with reply timeout and bounded retransmission, plus RS-485 driver control.
module mbt_master_port
    import mbt_pkg::*;
#(
    parameter int TIMEOUT_W = 24
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 cfg_configurable,
    input  wire logic [15:0]          cfg_offset,
    input  wire logic [7:0]           cfg_rd_fn,
    input  wire logic [7:0]           cfg_wr_fn,
    input  wire logic [1:0]           cfg_drv_mode,
    input  wire logic [TIMEOUT_W-1:0] cfg_timeout,
    input  wire logic                 req_valid,
    output logic                      req_ready,
    input  wire logic                 req_write,
    input  wire logic [15:0]          req_remote,
    input  wire logic [7:0]           req_fixed_fn,
    input  wire logic [15:0]          sl_mb_addr,
    output logic      [15:0]          sl_up_reg,
    output logic                      frm_valid,
    input  wire logic                 frm_ready,
    output logic      [7:0]           frm_fn,
    output logic      [15:0]          frm_addr,
    output logic      [1:0]           frm_attempt,
    input  wire logic                 frm_done,
    input  wire logic                 rply_ok,
    output logic                      req_ok,
    output logic                      req_abandon,
    input  wire logic                 cts_pin,
    output logic                      tx_oe,
    output logic                      rx_en
);
    localparam int QW = 1 + 16 + 8;

    typedef struct packed {
        mbt_state_t           st;
        logic [7:0]           fn;
        logic [15:0]          addr;
        logic [1:0]           attempt;
        logic [TIMEOUT_W-1:0] timer;
        logic                 frm_valid;
        logic                 sending;
        logic                 req_ok;
        logic                 req_abandon;
        logic [15:0]          sl_up_reg;
        logic                 cts_s1;
        logic                 cts_s2;
        logic                 tx_oe;
        logic                 rx_en;
    } mbt_st_t;

    mbt_st_t         s;
    mbt_st_t         next_s;
    logic            q_valid;
    logic            q_take;
    logic [QW-1:0]   q_data;
    logic            q_write;
    logic [15:0]     q_remote;
    logic [7:0]      q_fixed_fn;
    logic [15:0]     eff_offset;
    logic [15:0]     reg_addr;
    logic [7:0]      sel_fn;

    // Requests queue here so upstream need not stall while a slow slave is retried, until FIFO_DEPTH entries wait
    mbt_fifo #(
        .WIDTH (QW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (req_valid),
        .in_ready  (req_ready),
        .in_data   ({req_write, req_remote, req_fixed_fn}),
        .out_valid (q_valid),
        .out_ready (q_take),
        .out_data  (q_data)
    );

    assign {q_write, q_remote, q_fixed_fn} = q_data;
    assign q_take = q_valid && s.st == MBT_IDLE;

    always_comb begin
        eff_offset = cfg_configurable ? cfg_offset : OFFSET_RESET;      // [RQ2] [RQ4] [RQ17]
        sel_fn     = cfg_configurable ? (q_write ? cfg_wr_fn : cfg_rd_fn)
                                      : q_fixed_fn;                     // [RQ16] [RQ17]
        reg_addr   = 16'(q_remote + eff_offset);                        // [RQ1] [RQ18]
    end

    always_comb begin
        next_s             = s;
        next_s.req_ok      = 1'b0;
        next_s.req_abandon = 1'b0;
        next_s.cts_s1      = cts_pin;
        next_s.cts_s2      = s.cts_s1;
        next_s.sl_up_reg   = sl_mb_addr;                                // [RQ3]
        unique case (s.st)
            MBT_IDLE: begin
                if (q_valid) begin
                    next_s.fn        = sel_fn;
                    // Coil start is bit one of a sixteen-coil aligned group
                    next_s.addr      = is_coil_fn(sel_fn) ? coil_start(reg_addr)
                                                          : reg_addr; // [RQ6] [RQ7]
                    next_s.attempt   = 2'h0;
                    next_s.frm_valid = 1'b1;
                    next_s.st        = MBT_SEND;
                end
            end
            MBT_SEND: begin
                if (frm_ready) begin
                    next_s.frm_valid = 1'b0;
                    next_s.sending   = 1'b1;
                end
                if (s.sending && frm_done) begin
                    next_s.sending = 1'b0;
                    next_s.timer   = cfg_timeout;
                    next_s.st      = MBT_WAIT;
                end
            end
            MBT_WAIT: begin
                if (rply_ok) begin
                    next_s.req_ok = 1'b1;
                    next_s.st     = MBT_IDLE;
                end else if (s.timer != '0) begin
                    next_s.timer = TIMEOUT_W'(s.timer - 1'b1);
                end else if (s.attempt != MAX_RETRIES) begin
                    next_s.attempt   = 2'(s.attempt + 1'b1);            // [RQ8]
                    next_s.frm_valid = 1'b1;
                    next_s.st        = MBT_SEND;
                end else begin
                    next_s.req_abandon = 1'b1;                          // [RQ9]
                    next_s.st          = MBT_IDLE;
                end
            end
            default: next_s.st = MBT_IDLE;
        endcase
        unique case (cfg_drv_mode)
            MBT_DRV_FOLLOW: begin
                next_s.tx_oe = s.cts_s2;                                // [RQ11]
                next_s.rx_en = 1'b1;
            end
            MBT_DRV_TWO: begin
                next_s.tx_oe = s.cts_s2;                                // [RQ12]
                next_s.rx_en = !(s.cts_s2 || s.sending || s.frm_valid); // [RQ12]
            end
            default: begin
                next_s.tx_oe = 1'b1;                                    // [RQ10]
                next_s.rx_en = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s       <= '0;
            s.st    <= MBT_IDLE;
            s.rx_en <= 1'b1;
            s.tx_oe <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign frm_valid   = s.frm_valid;
    assign frm_fn      = s.fn;
    assign frm_addr    = s.addr;
    assign frm_attempt = s.attempt;
    assign req_ok      = s.req_ok;
    assign req_abandon = s.req_abandon;
    assign sl_up_reg   = s.sl_up_reg;
    assign tx_oe       = s.tx_oe;
    assign rx_en       = s.rx_en;

    property p_retry_limit;
        @(posedge clk) disable iff (rst) s.st == MBT_SEND |-> s.attempt <= MAX_RETRIES;
    endproperty
    a_retry_limit: assert property (p_retry_limit) else $error("too many sends"); // [RQ9]

    property p_abandon_after_three;
        @(posedge clk) disable iff (rst) req_abandon |-> $past(s.attempt) == MAX_RETRIES;
    endproperty
    a_abandon_after_three: assert property (p_abandon_after_three) // [RQ9]
        else $error("abandon early");

    sequence s_timed_out;
        s.st == MBT_WAIT && s.timer == '0 && !rply_ok && s.attempt != MAX_RETRIES;
    endsequence
    property p_resend;
        @(posedge clk) disable iff (rst) s_timed_out |=> frm_valid && s.st == MBT_SEND;
    endproperty
    a_resend: assert property (p_resend) else $error("no retransmit"); // [RQ8]

    property p_same_frame;
        @(posedge clk) disable iff (rst)
            s_timed_out |=> frm_addr == $past(frm_addr) && frm_fn == $past(frm_fn);
    endproperty
    a_same_frame: assert property (p_same_frame) else $error("resent frame differs"); // [RQ8]

    property p_reg_addr;
        @(posedge clk) disable iff (rst)
            q_take && !is_coil_fn(sel_fn) |=> frm_addr == 16'($past(q_remote)
                + ($past(cfg_configurable) ? $past(cfg_offset) : 16'h0000));
    endproperty
    a_reg_addr: assert property (p_reg_addr) else $error("register address wrong"); // [RQ1]

    property p_fixed_zero;
        @(posedge clk) disable iff (rst)
            q_take && !cfg_configurable && !is_coil_fn(sel_fn) |=> frm_addr == $past(q_remote);
    endproperty
    a_fixed_zero: assert property (p_fixed_zero) else $error("fixed offset not zero"); // [RQ2]

    property p_coil_addr;
        @(posedge clk) disable iff (rst)
            q_take && is_coil_fn(sel_fn) |=> frm_addr[3:0] == 4'h1;
    endproperty
    a_coil_addr: assert property (p_coil_addr) else $error("coil not aligned"); // [RQ7]

    property p_always_on;
        @(posedge clk) disable iff (rst)
            cfg_drv_mode == MBT_DRV_ALWAYS ##1 cfg_drv_mode == MBT_DRV_ALWAYS |-> tx_oe && rx_en;
    endproperty
    a_always_on: assert property (p_always_on) else $error("driver not on"); // [RQ10]

    property p_follow_cts;
        @(posedge clk) disable iff (rst)
            (cfg_drv_mode == MBT_DRV_FOLLOW || cfg_drv_mode == MBT_DRV_TWO)
                |=> tx_oe == $past(s.cts_s2);
    endproperty
    a_follow_cts: assert property (p_follow_cts) else $error("driver ignores cts"); // [RQ11]

    property p_two_wire_rx;
        @(posedge clk) disable iff (rst)
            cfg_drv_mode == MBT_DRV_TWO && s.sending |=> !rx_en;
    endproperty
    a_two_wire_rx: assert property (p_two_wire_rx) else $error("rx on during tx"); // [RQ12]
endmodule

// ==== mbt_slave_model.sv ====
// Modbus slave on the far side of the frame handshake: it takes a frame,
// reports it sent, then answers unless the attempt is below silent.
// Frame and reply delays stand in for a 9600 baud, 8E1 character stream
module mbt_slave_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       frm_valid,
    input  wire logic [1:0] frm_attempt,
    input  wire logic       hold,
    input  wire logic       slow,
    input  wire logic [1:0] silent,
    output logic            frm_ready,
    output logic            frm_done,
    output logic            rply_ok
);
    logic [3:0] cnt;
    logic       sending;
    logic       answering;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            frm_ready <= 1'b0;
            frm_done  <= 1'b0;
            rply_ok   <= 1'b0;
            cnt       <= 4'h0;
            sending   <= 1'b0;
            answering <= 1'b0;
        end else begin
            frm_done <= 1'b0;
            rply_ok  <= 1'b0;
            if (sending) begin
                if (cnt == 4'h0) begin
                    frm_done  <= 1'b1;
                    sending   <= 1'b0;
                    // A silent slave lets the port's reply timer run out
                    answering <= (frm_attempt >= silent);
                    cnt       <= slow ? 4'h4 : 4'h1;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end else if (answering) begin
                if (cnt == 4'h0) begin
                    rply_ok   <= 1'b1;
                    answering <= 1'b0;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end else if (frm_ready && frm_valid) begin
                frm_ready <= 1'b0;
                sending   <= 1'b1;
                cnt       <= slow ? 4'h6 : 4'h1;
            end else begin
                frm_ready <= !hold;
            end
        end
    end
endmodule

// ==== mbt_master_port_translator_test.sv ====
module mbt_master_port_translator_test;
    import mbt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        cfg;
        logic [15:0] off;
        logic [7:0]  fn;
        logic        wr;
        logic [15:0] rem;
        logic [15:0] ea;
    } mbt_row_t;

    logic        clk, rst, cfg_configurable, req_valid, req_write, cts_pin, hold, slow;
    logic [15:0] cfg_offset, req_remote, sl_mb_addr, sl_up_reg, frm_addr;
    logic [7:0]  cfg_rd_fn, cfg_wr_fn, req_fixed_fn, frm_fn;
    logic [1:0]  cfg_drv_mode, silent, frm_attempt;
    logic [23:0] cfg_timeout;
    logic        req_ready, frm_valid, frm_ready, frm_done, rply_ok, req_ok, req_abandon;
    logic        tx_oe, rx_en;
    int          num_errors, cmp_count, cyc, oks, abn, accs, n, k, o, a, c;
    mbt_row_t    rows [9] = '{ // Remote numbers all stay at or below 8192
        '{1'b1, 16'h0000, 8'h04, 1'b0, 16'h0079, 16'h0079},
        '{1'b1, 16'h0fa0, 8'h10, 1'b1, 16'h1437, 16'h23d7},
        '{1'b1, 16'h01f4, 8'h06, 1'b1, 16'h0001, 16'h01f5},
        '{1'b1, 16'hffff, 8'h03, 1'b0, 16'h0002, 16'h0001},
        '{1'b0, 16'h01f4, 8'h03, 1'b0, 16'h0007, 16'h0007},
        '{1'b1, 16'h0000, 8'h01, 1'b0, 16'h0002, 16'h0011},
        '{1'b1, 16'h0001, 8'h05, 1'b1, 16'h0006, 16'h0061},
        '{1'b1, 16'h0001, 8'h0f, 1'b1, 16'h0001, 16'h0011},
        '{1'b0, 16'h01f4, 8'h01, 1'b0, 16'h0003, 16'h0021}};
    // Mode, CTS, expected transmitter enable, expected receiver enable
    // Modes 00/11 model an always-on full-duplex line, 01 a tx_follows_handshake full-duplex one, 10 a two-wire half-duplex one
    logic [4:0]  drv [6] = '{5'b00011, 5'b01001, 5'b01111, 5'b10110, 5'b10001,
                             5'b11011};

    mbt_master_port u_dut (.clk, .rst, .cfg_configurable, .cfg_offset, .cfg_rd_fn,
        .cfg_wr_fn, .cfg_drv_mode, .cfg_timeout, .req_valid, .req_ready, .req_write,
        .req_remote, .req_fixed_fn, .sl_mb_addr, .sl_up_reg, .frm_valid, .frm_ready,
        .frm_fn, .frm_addr, .frm_attempt, .frm_done, .rply_ok, .req_ok, .req_abandon,
        .cts_pin, .tx_oe, .rx_en);
    mbt_slave_model u_slave (.clk, .rst, .frm_valid, .frm_attempt, .hold, .slow,
        .silent, .frm_ready, .frm_done, .rply_ok);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic end_of_test();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Valid goes up off the sampling edge and drops only after the taking edge
    task automatic push();
        @(negedge clk);
        req_valid = 1'b1;
        for (k = 0; k < 50 && req_ready !== 1'b1; k++) @(negedge clk);
        @(negedge clk);
        req_valid = 1'b0;
    endtask

    task automatic wait_done(input int o0, input int a0);
        for (k = 0; k < 300 && oks == o0 && abn == a0; k++) @(negedge clk);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (req_ok === 1'b1) oks++;
        if (req_abandon === 1'b1) abn++;
        if (frm_valid === 1'b1 && frm_ready === 1'b1) accs++;
        if (cyc == 20000) begin
            num_errors++;
            end_of_test();
        end
    end

    initial begin
        {rst, req_valid, req_write, cts_pin, hold, slow, cfg_configurable} = 7'h41;
        {cfg_offset, req_remote, sl_mb_addr} = '0;
        {cfg_rd_fn, cfg_wr_fn, req_fixed_fn, cfg_drv_mode, silent} = '0;
        cfg_timeout = 24'h000005;
        repeat (2) @(negedge clk);
        chk("tx_oe", 16'h0001, {15'h0, tx_oe});
        chk("frm_valid", 16'h0000, {15'h0, frm_valid});
        chk("req_ready", 16'h0001, {15'h0, req_ready});
        @(negedge clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            @(negedge clk);
            cfg_configurable = rows[i].cfg;
            cfg_offset = rows[i].off;
            cfg_rd_fn = (rows[i].cfg && !rows[i].wr) ? rows[i].fn : 8'h02;
            cfg_wr_fn = (rows[i].cfg && rows[i].wr) ? rows[i].fn : 8'h02;
            req_fixed_fn = rows[i].cfg ? 8'h02 : rows[i].fn;
            req_write = rows[i].wr;
            req_remote = rows[i].rem;
            o = oks;
            push();
            for (k = 0; k < 50 && frm_valid !== 1'b1; k++) @(negedge clk);
            chk("frm_fn", {8'h0, rows[i].fn}, {8'h0, frm_fn});
            chk("frm_addr", rows[i].ea, frm_addr);
            wait_done(o, abn);
        end
        for (int s = 2; s < 4; s++) begin
            silent = 2'(s);
            slow = (s == 3);
            {o, a, c} = {oks, abn, accs};
            push();
            wait_done(o, a);
            repeat (30) @(negedge clk);
            chk("sends", 16'h0003, 16'(accs - c));
            chk("ok", 16'(s == 2), 16'(oks - o));
            chk("abandon", 16'(s == 3), 16'(abn - a));
        end
        silent = 2'h0;
        {cfg_configurable, cfg_offset, sl_mb_addr} = {1'b1, 16'h01f4, 16'h0079};
        repeat (2) @(negedge clk);
        chk("sl_up_reg", 16'h0079, sl_up_reg);
        foreach (drv[i]) begin
            {cfg_drv_mode, cts_pin} = drv[i][4:2];
            repeat (5) @(negedge clk);
            chk("tx_oe", {15'h0, drv[i][1]}, {15'h0, tx_oe});
            chk("rx_en", {15'h0, drv[i][0]}, {15'h0, rx_en});
        end
        // Far side stalls while the queue fills, then drains it completely
        // Two-wire mode here so frames really flow with the receiver gated
        {cfg_drv_mode, hold, o, n} = {2'b10, 1'b1, oks, 32'd0};
        @(negedge clk);
        req_valid = 1'b1;
        for (int i = 0; i < 40; i++) begin
            if (req_ready === 1'b1) n++;
            @(negedge clk);
        end
        req_valid = 1'b0;
        chk("full", 16'h0000, {15'h0, req_ready});
        chk("fill", 16'h0001, 16'(n >= FIFO_DEPTH));
        chk("rx_en_pending", 16'h0000, {15'h0, rx_en});
        hold = 1'b0;
        for (k = 0; k < 3000 && oks < o + n; k++) @(negedge clk);
        chk("drained", 16'(n), 16'(oks - o));
        chk("empty", 16'h0001, {15'h0, req_ready});
        end_of_test();
    end
endmodule
